// [inc/nfs_pkg.sv]
// Shared constants and types for the flash strobe sequencer.
package nfs_pkg;

    // ------------------------------------------------------------------
    // System clock and flash controller clock limits
    // ------------------------------------------------------------------
    localparam int SYS_CLK_KHZ       = 125000;
    localparam int FLASH_CLK_MAX_KHZ = 66000;
    localparam int FLASH_CLK_DEF_KHZ = 16630;

    // The controller clock period is counted in system cycles, rounded so that it never runs faster than asked.
    localparam int T_CYC_MIN = (SYS_CLK_KHZ + FLASH_CLK_MAX_KHZ - 1) / FLASH_CLK_MAX_KHZ;
    localparam int T_CYC_DEF = (SYS_CLK_KHZ + FLASH_CLK_DEF_KHZ - 1) / FLASH_CLK_DEF_KHZ;
    localparam int HALF_MIN  = (T_CYC_MIN + 1) / 2;
    localparam int HALF_DEF  = (T_CYC_DEF + 1) / 2;

    // Suggested divider ratios for a 266 MHz core clock.
    localparam int CORE_CLK_KHZ  = 266000;
    localparam int DIV_SUGGEST_A = 12;
    localparam int DIV_SUGGEST_B = 8;

    // ------------------------------------------------------------------
    // Strobe phase lengths in half controller periods
    // ------------------------------------------------------------------
    localparam int WR_SETUP_HT = 2;
    localparam int WR_PULSE_HT = 2;
    localparam int WR_HOLD_HT  = 2;
    localparam int RD_WAIT_HT  = 8;
    localparam int RD_LOW_HT   = 3;
    localparam int RD_HIGH_HT  = 1;
    localparam int PHASE_W     = 4;

    // Read data must be stable this long before the sampling edge.
    localparam int DATA_SETUP_NS = 15;

    // ------------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        NFS_OP_CMD,
        NFS_OP_ADDR,
        NFS_OP_WRITE,
        NFS_OP_READ
    } nfs_op_type;

    typedef enum logic [2:0] {
        NFS_IDLE,
        NFS_WR_SETUP,
        NFS_WR_LOW,
        NFS_WR_HOLD,
        NFS_RD_WAIT,
        NFS_RD_LOW,
        NFS_RD_HIGH
    } nfs_state_type;

endpackage

// [core/nfs_fifo.sv]
// Small first-in first-out buffer with a registered output word.
module nfs_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("nfs_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0]   cnt_q;
    logic          out_valid_q;
    logic [W-1:0]  out_data_q;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign push        = in_valid_i && in_ready_o;
    // The output word reloads when it is empty or being taken, so a stalled reader really fills the store.
    assign pop         = (cnt_q != '0) && (!out_valid_q || out_ready_i);
    assign out_valid_o = out_valid_q;
    assign out_data_o  = out_data_q;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            wptr_q      <= '0;
            rptr_q      <= '0;
            cnt_q       <= '0;
            out_valid_q <= 1'b0;
            out_data_q  <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q      <= rptr_q + 1'b1;
                out_data_q  <= mem_q[rptr_q];
                out_valid_q <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_q <= 1'b0;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

// [core/nfs_core.sv]
// Strobe sequencer that drives latch, select, write and read strobes toward a NAND flash.

// Operation
// - All strobe intervals counted in half controller periods.
// - Write setup, hold, pulse each one period.
// - Read waits 4T, low 1.5T, high 0.5T.
// - Controller clock never above its maximum.
// - Controller clock starts at default frequency.
// - Divider divides source clock by programmed ratio, odd ratios rounded up to even, at least 2.
// - Read data sampled on controller clock edge.
module nfs_core #(
    parameter int DATA_W     = 8,
    parameter int DIV_W      = 8,
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,

    // Command side.
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire logic [1:0]        cmd_kind_i,
    input  wire logic [DATA_W-1:0] cmd_data_i,

    // Divider programming, system cycles per controller period.
    input  wire logic [DIV_W-1:0]  flash_clock_divider_i,
    input  wire logic              div_load_i,

    // Read data stream.
    output logic                   rd_valid_o,
    input  wire logic              rd_ready_i,
    output logic [DATA_W-1:0]      rd_data_o,
    output logic                   busy_o,

    // Flash pins.
    output logic                   cmd_latch_enable_o,
    output logic                   addr_latch_enable_o,
    output logic                   flash_chip_select_n_o,
    output logic                   flash_write_strobe_n_o,
    output logic                   flash_read_strobe_n_o,
    output logic [DATA_W-1:0]      flash_data_o,
    output logic                   flash_data_oe_n_o,
    input  wire logic [DATA_W-1:0] flash_data_i,
    input  wire logic              flash_ready_i
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DIV_W < 4 || DIV_W > 16) begin : g_chk_div
        $error("nfs_core: DIV_W must lie between 4 and 16");
    end

    if (DATA_W < 1) begin : g_chk_data
        $error("nfs_core: DATA_W must be at least 1");
    end

    if (nfs_pkg::HALF_DEF >= (1 << DIV_W)) begin : g_chk_def
        $error("nfs_core: DIV_W too narrow for the default divider");
    end

    // Divider constants sized to the counters.
    localparam logic [DIV_W-1:0]   HALF_MIN_V = DIV_W'(nfs_pkg::HALF_MIN);
    localparam logic [DIV_W-1:0]   HALF_DEF_V = DIV_W'(nfs_pkg::HALF_DEF);

    localparam logic [DIV_W-1:0]   DIV_ONE    = DIV_W'(1);
    localparam logic [nfs_pkg::PHASE_W-1:0] PH_ONE = nfs_pkg::PHASE_W'(1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        nfs_pkg::nfs_state_type st;
        logic [DIV_W-1:0]             div_half;
        logic [DIV_W-1:0]             div_cnt;
        logic [nfs_pkg::PHASE_W-1:0]  phase;

        // Registered pin levels.
        logic                         cle;
        logic                         ale;
        logic                         cs_n;
        logic                         we_n;
        logic                         re_n;
        logic [DATA_W-1:0]            io_out;
        logic                         io_oe_n;

        // Two-flop pin synchronisers.
        logic                         rdy_meta;
        logic                         rdy_sync;
        logic [DATA_W-1:0]            io_meta;
        logic [DATA_W-1:0]            io_sync;

        // Captured byte and buffer write.
        logic [DATA_W-1:0]            rd_data;
        logic                         push;
    } nfs_core_state_type;

    nfs_core_state_type q;
    nfs_core_state_type d;

    // Combinational helpers.
    logic                        fifo_in_ready;
    logic                        tick;
    logic                        phase_done;
    logic [nfs_pkg::PHASE_W-1:0] phase_lim;
    logic [DIV_W-1:0]            req_half;
    nfs_pkg::nfs_op_type         kind;

    assign kind = nfs_pkg::nfs_op_type'(cmd_kind_i);

    // A read is only started with room for its byte, so the buffer can never overflow.
    assign cmd_ready_o = (q.st == nfs_pkg::NFS_IDLE)
                      && ((kind != nfs_pkg::NFS_OP_READ) || (fifo_in_ready && !q.push));

    // The half period is the divider ratio halved and rounded up, then held at the floor.
    always_comb begin
        req_half = (flash_clock_divider_i >> 1) + DIV_W'(flash_clock_divider_i[0]);
        if (req_half < HALF_MIN_V) begin
            req_half = HALF_MIN_V;
        end
    end

    // ------------------------------------------------------------------
    // Controller clock tick and phase length
    // ------------------------------------------------------------------
    assign tick = (q.div_cnt == '0);

    // Phase length of each state, in half controller periods.
    always_comb begin
        case (q.st)
            nfs_pkg::NFS_WR_SETUP: phase_lim = nfs_pkg::PHASE_W'(nfs_pkg::WR_SETUP_HT);
            nfs_pkg::NFS_WR_LOW:   phase_lim = nfs_pkg::PHASE_W'(nfs_pkg::WR_PULSE_HT);
            nfs_pkg::NFS_WR_HOLD:  phase_lim = nfs_pkg::PHASE_W'(nfs_pkg::WR_HOLD_HT);
            nfs_pkg::NFS_RD_WAIT:  phase_lim = nfs_pkg::PHASE_W'(nfs_pkg::RD_WAIT_HT);
            nfs_pkg::NFS_RD_LOW:   phase_lim = nfs_pkg::PHASE_W'(nfs_pkg::RD_LOW_HT);
            nfs_pkg::NFS_RD_HIGH:  phase_lim = nfs_pkg::PHASE_W'(nfs_pkg::RD_HIGH_HT);
            default:               phase_lim = PH_ONE;
        endcase
    end

    // A phase ends on the tick that completes its last half period.
    assign phase_done = tick && (q.phase == phase_lim - PH_ONE);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d          = q;
        d.push     = 1'b0;
        d.rdy_meta = flash_ready_i;
        d.rdy_sync = q.rdy_meta;
        d.io_meta  = flash_data_i;
        d.io_sync  = q.io_meta;

        // The divider runs on its own and marks each half period.
        if (tick) begin
            d.div_cnt = q.div_half - DIV_ONE;
        end else begin
            d.div_cnt = q.div_cnt - DIV_ONE;
        end

        if (tick) begin
            d.phase = phase_done ? '0 : q.phase + PH_ONE;
        end

        case (q.st)
            nfs_pkg::NFS_IDLE: begin
                d.phase   = '0;
                d.cle     = 1'b0;
                d.ale     = 1'b0;
                d.cs_n    = 1'b1;
                d.we_n    = 1'b1;
                d.re_n    = 1'b1;
                d.io_oe_n = 1'b1;

                // Changing the ratio mid-transfer would shorten a phase, so it is taken only while idle.
                if (div_load_i) begin
                    d.div_half = req_half;
                end

                if (cmd_valid_i && cmd_ready_o) begin
                    // Restart the divider so the first phase gets its full length.
                    d.div_cnt = q.div_half - DIV_ONE;
                    d.cs_n    = 1'b0;
                    if (kind == nfs_pkg::NFS_OP_READ) begin
                        d.st = nfs_pkg::NFS_RD_WAIT;
                    end else begin
                        d.st      = nfs_pkg::NFS_WR_SETUP;
                        d.cle     = (kind == nfs_pkg::NFS_OP_CMD);
                        d.ale     = (kind == nfs_pkg::NFS_OP_ADDR);
                        d.io_out  = cmd_data_i;
                        d.io_oe_n = 1'b0;
                    end
                end
            end

            nfs_pkg::NFS_WR_SETUP: begin
                if (phase_done) begin
                    d.we_n = 1'b0;
                    d.st   = nfs_pkg::NFS_WR_LOW;
                end
            end

            nfs_pkg::NFS_WR_LOW: begin
                if (phase_done) begin
                    d.we_n = 1'b1;
                    d.st   = nfs_pkg::NFS_WR_HOLD;
                end
            end

            nfs_pkg::NFS_WR_HOLD: begin
                if (phase_done) begin
                    d.cle     = 1'b0;
                    d.ale     = 1'b0;
                    d.cs_n    = 1'b1;
                    d.io_oe_n = 1'b1;
                    d.st      = nfs_pkg::NFS_IDLE;
                end
            end

            nfs_pkg::NFS_RD_WAIT: begin
                if (!q.rdy_sync) begin
                    // The wait restarts whenever the flash drops ready again.
                    d.phase   = '0;
                    d.div_cnt = q.div_half - DIV_ONE;
                end else if (phase_done) begin
                    d.re_n = 1'b0;
                    d.st   = nfs_pkg::NFS_RD_LOW;
                end
            end

            nfs_pkg::NFS_RD_LOW: begin
                if (phase_done) begin
                    // The synchroniser adds two system cycles, which covers the flash data setup window.
                    d.rd_data = q.io_sync;
                    d.push    = 1'b1;
                    d.re_n    = 1'b1;
                    d.st      = nfs_pkg::NFS_RD_HIGH;
                end
            end

            nfs_pkg::NFS_RD_HIGH: begin
                // Recovery time before the select is released.
                if (phase_done) begin
                    d.cs_n = 1'b1;
                    d.st   = nfs_pkg::NFS_IDLE;
                end
            end

            default: begin
                d.st = nfs_pkg::NFS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            // Pins park at their idle levels while reset is held.
            q          <= '0;
            q.st       <= nfs_pkg::NFS_IDLE;
            q.div_half <= HALF_DEF_V;
            q.cs_n     <= 1'b1;
            q.we_n     <= 1'b1;
            q.re_n     <= 1'b1;
            q.io_oe_n  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Read data buffer
    // ------------------------------------------------------------------
    // A read is refused, never dropped, while this store is full.
    nfs_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_valid_i  (q.push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (q.rd_data),
        .out_valid_o (rd_valid_o),
        .out_ready_i (rd_ready_i),
        .out_data_o  (rd_data_o)
    );

    assign busy_o                 = (q.st != nfs_pkg::NFS_IDLE);

    // Every pin comes straight from a register, so none can glitch.
    assign cmd_latch_enable_o     = q.cle;
    assign addr_latch_enable_o    = q.ale;
    assign flash_chip_select_n_o  = q.cs_n;
    assign flash_write_strobe_n_o = q.we_n;
    assign flash_read_strobe_n_o  = q.re_n;
    assign flash_data_o           = q.io_out;
    assign flash_data_oe_n_o      = q.io_oe_n;

endmodule

// [verif/nfs_core_monitor.sv]
// Concurrent checks on the pins of the flash strobe sequencer.
module nfs_monitor #(
    parameter int DATA_W = 8,
    parameter int DIV_W  = 8
) (
    input wire logic              clk_sys_i,
    input wire logic              rst_i,
    input wire logic [DIV_W-1:0]  flash_clock_divider_i,
    input wire logic              div_load_i,
    input wire logic              busy_o,
    input wire logic              cmd_latch_enable_o,
    input wire logic              addr_latch_enable_o,
    input wire logic              flash_chip_select_n_o,
    input wire logic              flash_write_strobe_n_o,
    input wire logic              flash_read_strobe_n_o,
    input wire logic [DATA_W-1:0] flash_data_o,
    input wire logic              flash_data_oe_n_o,
    input wire logic              flash_ready_i
);
    timeunit 1ns;
    timeprecision 1ps;
    wire         we_n = flash_write_strobe_n_o;
    wire         re_n = flash_read_strobe_n_o;
    wire         cs_n = flash_chip_select_n_o;
    wire         oe_n = flash_data_oe_n_o;
    logic [11:0] half_q, cs_q, we_q, re_q, rdy_q;
    // ----------------------------------------------------------------
    // Helper counters
    // ----------------------------------------------------------------
    // The half period mirrors the divider so pulse widths are checked exactly, not just against a floor.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            half_q <= 12'h004;
            cs_q   <= 12'h000;
            we_q   <= 12'h000;
            re_q   <= 12'h000;
            rdy_q  <= 12'h000;
        end else begin
            if (div_load_i && !busy_o) begin
                half_q <= (flash_clock_divider_i < 2) ? 12'h001 : 12'((32'(flash_clock_divider_i) + 1) / 2);
            end
            cs_q  <= cs_n ? 12'h000 : cs_q + 12'h001;
            we_q  <= we_n ? 12'h000 : we_q + 12'h001;
            re_q  <= re_n ? 12'h000 : re_q + 12'h001;
            rdy_q <= !flash_ready_i ? 12'h000 : rdy_q + {11'h000, rdy_q != 12'hfff};
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    a_we_pulse_width: assert property ($rose(we_n) |-> we_q == 2 * half_q)
        else $error("write strobe low time wrong");
    a_we_setup_time: assert property ($fell(we_n) |-> cs_q == 2 * half_q)
        else $error("write strobe setup time wrong");
    a_write_data_held: assert property ((!we_n || $rose(we_n)) |-> !cs_n && !oe_n && $stable(flash_data_o))
        else $error("write data or select not held around strobe");
    a_re_pulse_width: assert property ($rose(re_n) |-> re_q == 3 * half_q && !cs_n)
        else $error("read strobe low time wrong");
    a_re_ready_wait: assert property ($fell(re_n) |-> rdy_q >= 8 * half_q)
        else $error("read strobe fell too soon after ready");
    a_re_bus_free: assert property (!re_n |-> !cs_n && oe_n)
        else $error("bus driven during read strobe");
    a_latch_excl: assert property (!(cmd_latch_enable_o && addr_latch_enable_o))
        else $error("both latch enables high");
    a_reset_idle: assert property (disable iff (1'b0) rst_i |=> cs_n && we_n && re_n && oe_n && !busy_o)
        else $error("pins not idle after reset");
    c_cmd_write: cover property ($fell(we_n) && cmd_latch_enable_o);
    c_read: cover property ($fell(re_n));
    c_div_load: cover property (div_load_i && !busy_o);
endmodule

bind nfs_core nfs_monitor #(
    .DATA_W (DATA_W),
    .DIV_W  (DIV_W)
) nfs_monitor_inst (
    .clk_sys_i              (clk_sys_i),
    .rst_i                  (rst_i),
    .flash_clock_divider_i  (flash_clock_divider_i),
    .div_load_i             (div_load_i),
    .busy_o                 (busy_o),
    .cmd_latch_enable_o     (cmd_latch_enable_o),
    .addr_latch_enable_o    (addr_latch_enable_o),
    .flash_chip_select_n_o  (flash_chip_select_n_o),
    .flash_write_strobe_n_o (flash_write_strobe_n_o),
    .flash_read_strobe_n_o  (flash_read_strobe_n_o),
    .flash_data_o           (flash_data_o),
    .flash_data_oe_n_o      (flash_data_oe_n_o),
    .flash_ready_i          (flash_ready_i)
);

// [verif/nfs_flash_model.sv]
// Behavioural NAND flash at the far side of the strobe sequencer.
module nfs_flash_model (
    input  wire logic        clk_sys_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        cmd_latch_i,
    input  wire logic        addr_latch_i,
    input  wire logic        write_strobe_n_i,
    input  wire logic        read_strobe_n_i,
    input  wire logic [7:0]  bus_i,
    input  wire logic [15:0] busy_cycles_i,
    output logic             ready_o,
    output logic [7:0]       data_o,
    output logic [7:0]       wr_byte_o,
    output logic [1:0]       wr_kind_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   busy_left = 0;
    int   rd_idx    = 0;
    logic cmd_seen  = 1'b0;
    initial data_o = 8'h00;
    assign ready_o = (busy_left == 0);
    // A command byte starts an internal busy period, so the ready wait is exercised slowly as well as promptly.
    always @(posedge write_strobe_n_i) begin
        if (!chip_select_n_i) begin
            wr_byte_o = bus_i;
            wr_kind_o = {cmd_latch_i, addr_latch_i};
            cmd_seen  = cmd_latch_i;
        end
    end
    always @(posedge clk_sys_i) begin
        if (cmd_seen) begin
            busy_left <= int'(busy_cycles_i);
            cmd_seen  <= 1'b0;
        end else if (busy_left > 0) begin
            busy_left <= busy_left - 1;
        end
    end
    // Data comes 10 ns after the strobe falls; on release the bus shows the inverse so stale values never match.
    always @(negedge read_strobe_n_i) begin
        if (!chip_select_n_i) begin
            #10;
            data_o = 8'h3c + 8'(rd_idx);
        end
    end
    always @(posedge read_strobe_n_i) begin
        if (!chip_select_n_i) begin
            data_o = ~data_o;
            rd_idx++;
        end
    end
endmodule

// [verif/testbench.sv]
// Self-checking testbench for the flash strobe sequencer.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [1:0]  cmd_kind  = 2'h0;
    logic [7:0]  cmd_data  = 8'h00;
    logic [7:0]  div_val   = 8'h08;
    logic        div_load  = 1'b0;
    logic        rd_ready  = 1'b0;
    logic [15:0] busy_cyc  = 16'h0000;
    logic        cmd_ready, rd_valid, busy, cle, ale, cs_n, we_n, re_n, oe_n, ready;
    logic [7:0]  rd_data, dsn_data, mdl_data, bus_in, wr_byte;
    logic [1:0]  wr_kind;
    int          failures = 0;
    int          checked  = 0;
    int          half     = 4;
    int          rd_n     = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    assign bus_in = oe_n ? mdl_data : dsn_data;
    nfs_core nfs_core_inst (
        .clk_sys_i              (clk_sys_i),
        .rst_i                  (rst_i),
        .cmd_valid_i            (cmd_valid),
        .cmd_ready_o            (cmd_ready),
        .cmd_kind_i             (cmd_kind),
        .cmd_data_i             (cmd_data),
        .flash_clock_divider_i  (div_val),
        .div_load_i             (div_load),
        .rd_valid_o             (rd_valid),
        .rd_ready_i             (rd_ready),
        .rd_data_o              (rd_data),
        .busy_o                 (busy),
        .cmd_latch_enable_o     (cle),
        .addr_latch_enable_o    (ale),
        .flash_chip_select_n_o  (cs_n),
        .flash_write_strobe_n_o (we_n),
        .flash_read_strobe_n_o  (re_n),
        .flash_data_o           (dsn_data),
        .flash_data_oe_n_o      (oe_n),
        .flash_data_i           (bus_in),
        .flash_ready_i          (ready)
    );
    nfs_flash_model nfs_flash_model_inst (
        .clk_sys_i        (clk_sys_i),
        .chip_select_n_i  (cs_n),
        .cmd_latch_i      (cle),
        .addr_latch_i     (ale),
        .write_strobe_n_i (we_n),
        .read_strobe_n_i  (re_n),
        .bus_i            (dsn_data),
        .busy_cycles_i    (busy_cyc),
        .ready_o          (ready),
        .data_o           (mdl_data),
        .wr_byte_o        (wr_byte),
        .wr_kind_o        (wr_kind)
    );
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return cmd_ready;
            1: return busy;
            2: return we_n;
            3: return re_n;
            4: return ready;
            default: return rd_valid;
        endcase
    endfunction
    // Counts edges until the chosen signal is sampled at the wanted level; a hang ends the run.
    task automatic wait_for(input int sel, input logic lvl, output int n);
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (n > 4000) begin
                failures++;
                $display("[ERR] wait %0d expected done seen timeout", sel);
                give_verdict();
            end
        end while (pick(sel) !== lvl);
    endtask
    task automatic send(input logic [1:0] kind, input logic [7:0] data);
        int n;
        cmd_kind  <= kind;
        cmd_data  <= data;
        cmd_valid <= 1'b1;
        wait_for(0, 1'b1, n);
        cmd_valid <= 1'b0;
    endtask
    task automatic write_one(input logic [1:0] kind, input logic [7:0] data);
        int n;
        int w;
        send(kind, data);
        wait_for(2, 1'b0, n);
        wait_for(2, 1'b1, w);
        check("write_pulse", 16'(2 * half), 16'(w));
        wait_for(1, 1'b0, n);
        check("written_byte", {8'h00, data}, {8'h00, wr_byte});
        check("written_kind", {14'h0000, kind == 2'h0, kind == 2'h1}, {14'h0000, wr_kind});
    endtask
    task automatic read_one();
        int n;
        int g;
        int w;
        send(2'h3, 8'h00);
        wait_for(4, 1'b1, n);
        wait_for(3, 1'b0, g);
        check("ready_gap_in_range", 16'h0001, {15'h0000, g >= 8 * half && g <= 8 * half + 4});
        wait_for(3, 1'b1, w);
        check("read_pulse", 16'(3 * half), 16'(w));
        wait_for(1, 1'b0, n);
    endtask
    task automatic pop();
        int n;
        rd_ready <= 1'b1;
        wait_for(5, 1'b1, n);
        rd_ready <= 1'b0;
        check("read_byte", {8'h00, 8'h3c + 8'(rd_n)}, {8'h00, rd_data});
        rd_n++;
        @(posedge clk_sys_i);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_write_kinds();
        for (int k = 0; k < 3; k++) begin
            write_one(2'(k), 8'ha0 + 8'(k));
        end
    endtask
    task automatic s_reads();
        busy_cyc <= 16'h003c;
        write_one(2'h0, 8'h30);
        read_one();
        pop();
        busy_cyc <= 16'h0000;
        read_one();
        pop();
    endtask
    task automatic s_fifo_full();
        for (int i = 0; i < 5; i++) begin
            read_one();
        end
        cmd_kind <= 2'h3;
        repeat (2) @(posedge clk_sys_i);
        check("read_refused", 16'h0000, {15'h0000, cmd_ready});
        for (int i = 0; i < 5; i++) begin
            pop();
        end
        check("stream_empty", 16'h0000, {15'h0000, rd_valid});
    endtask
    task automatic s_divider();
        int n;
        int ratios[4] = '{12, 8, 2, 1};
        foreach (ratios[i]) begin
            div_val  <= 8'(ratios[i]);
            div_load <= 1'b1;
            @(posedge clk_sys_i);
            div_load <= 1'b0;
            half = (ratios[i] < 2) ? 1 : (ratios[i] + 1) / 2;
            write_one(2'h2, 8'h50 + 8'(i));
        end
        send(2'h2, 8'h66);
        div_val  <= 8'h40;
        div_load <= 1'b1;
        @(posedge clk_sys_i);
        div_load <= 1'b0;
        wait_for(1, 1'b0, n);
        write_one(2'h2, 8'h67);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        check("idle_pins", 16'h00f0, {8'h00, cs_n, we_n, re_n, oe_n, busy, rd_valid, cle, ale});
        s_write_kinds();
        s_reads();
        s_fifo_full();
        s_divider();
        give_verdict();
    end
endmodule
